// ---- rtl/cfi_geometry_defs.vh ----
`ifndef CFI_GEOMETRY_DEFS_VH
`define CFI_GEOMETRY_DEFS_VH

// word offsets of the query table
`define OFS_CORE_MIN        8'h1b
`define OFS_CORE_MAX        8'h1c
`define OFS_PROG_MIN        8'h1d
`define OFS_PROG_MAX        8'h1e
`define OFS_TYP_WORD        8'h1f
`define OFS_TYP_BUF         8'h20
`define OFS_TYP_BLK         8'h21
`define OFS_TYP_CHIP        8'h22
`define OFS_MAX_WORD        8'h23
`define OFS_MAX_BUF         8'h24
`define OFS_MAX_BLK         8'h25
`define OFS_MAX_CHIP        8'h26
`define OFS_SIZE            8'h27
`define OFS_IFW_LO          8'h28
`define OFS_IFW_HI          8'h29
`define OFS_WBUF_LO         8'h2a
`define OFS_WBUF_HI         8'h2b
`define OFS_REGION_CNT      8'h2c
`define OFS_REGION1         8'h2d
`define OFS_REGION2         8'h31
`define OFS_RSVD_FIRST      8'h35
`define OFS_RSVD_LAST       8'h38

// fixed values
`define VAL_CORE_MIN        8'h17
`define VAL_CORE_MAX        8'h20
`define VAL_PROG_MIN        8'h85
`define VAL_PROG_MAX        8'h95
`define VAL_TYP_WORD        8'h09
`define VAL_TYP_BUF         8'h0a
`define VAL_TYP_BLK         8'h0a
`define VAL_TYP_CHIP        8'h00
`define VAL_MAX_WORD        8'h01
`define VAL_MAX_BUF         8'h02
`define VAL_MAX_BLK         8'h02
`define VAL_MAX_CHIP        8'h00
`define VAL_SIZE_512M       8'h1a
`define VAL_SIZE_1G2G       8'h1b
`define VAL_IFW             16'h0001
`define VAL_WBUF            16'h000a
`define VAL_REGIONS_PARAM   8'h02
`define VAL_REGIONS_SYM     8'h01

// region descriptors, byte 0 in bits 7:0
`define DESC_MAIN_PARAM_512 32'h0200_01fe
`define DESC_MAIN_PARAM_1G  32'h0200_03fe
`define DESC_MAIN_SYM_512   32'h0200_01ff
`define DESC_MAIN_SYM_1G2G  32'h0200_03ff
`define DESC_SMALL          32'h0080_0003
`define DESC_NONE           32'h0000_0000

// reset values of the read path
`define RST_OFFSET          8'h00
`define RST_DATA            16'h0000

// density and placement codes
`define DENS_512M           2'h0
`define DENS_1G             2'h1
`define DENS_2G             2'h2
`define PLACE_TOP           2'h0
`define PLACE_BOTTOM        2'h1
`define PLACE_SYM           2'h2

`endif

// ---- rtl/cfi_geometry_query_table.v ----
// What this block does
// - word 1Bh returns 17
// - word 1Ch returns 20
// - words 1Dh and 1Eh return 85, 95
// - word 1Fh returns 09
// - word 20h returns 0A
// - word 21h returns 0A
// - words 22h and 26h return 00
// - word 23h returns 01
// - word 24h returns 02
// - word 25h returns 02
// - word 27h size exponent 1A or 1B
// - words 28h, 29h return 01, 00
// - words 2Ah, 2Bh return 0A, 00
// - word 2Ch region count 02 or 01
// - region descriptors: count y, size z, little-endian
// - top/bottom: main and small regions swap
// - symmetric: one region; 35h-38h read zero
// - upper data byte always zero
// - table served only in query mode
`timescale 1ns/1ps
`include "cfi_geometry_defs.vh"

module cfi_geometry_query_table #(
  parameter [1:0] density   = `DENS_512M,
  parameter [1:0] placement = `PLACE_TOP
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        query_mode,
  input  wire        rd_en,
  input  wire [7:0]  word_addr,
  output reg  [15:0] rd_data,
  output reg         rd_valid
);

  reg  [7:0] rom_offset_reg;
  wire [7:0] table_byte;

  // offset sampled so the lookup sits between two flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_offset_reg <= `RST_OFFSET;
    end else if (rd_en && query_mode) begin
      rom_offset_reg <= word_addr;
    end
  end

  cfi_table_rom #(
    .density   (density),
    .placement (placement)
  ) u_rom (
    .offset   (rom_offset_reg),
    .byte_out (table_byte)
  );

  reg rd_pending_reg;

  // two-cycle read: capture address, then drive table byte
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_pending_reg <= 1'b0;
      rd_valid       <= 1'b0;
      rd_data        <= `RST_DATA;
    end else begin
      rd_pending_reg <= rd_en && query_mode;
      rd_valid       <= rd_pending_reg;
      if (rd_pending_reg) begin
        rd_data <= {8'h00, table_byte};
      end
    end
  end

endmodule // cfi_geometry_query_table

// ---- rtl/cfi_table_rom.v ----
`timescale 1ns/1ps
`include "cfi_geometry_defs.vh"

// pure lookup of one table byte from a word offset
module cfi_table_rom #(
  parameter [1:0] density   = `DENS_512M,
  parameter [1:0] placement = `PLACE_TOP
) (
  input  wire [7:0] offset,
  output reg  [7:0] byte_out
);

  reg  [31:0] region1;
  reg  [31:0] region2;
  reg  [7:0]  size_exp;
  reg  [7:0]  region_cnt;
  wire [7:0]  rel1;
  wire [7:0]  rel2;
  wire [15:0] ifw_code;
  wire [15:0] wbuf_code;

  assign rel1 = offset - `OFS_REGION1;
  assign rel2 = offset - `OFS_REGION2;
  // two-byte fields named as wires, a literal cannot be part-selected
  assign ifw_code  = `VAL_IFW;
  assign wbuf_code = `VAL_WBUF;

  // variant-dependent geometry fields
  always @* begin
    size_exp   = (density == `DENS_512M) ? `VAL_SIZE_512M
                                         : `VAL_SIZE_1G2G;
    region_cnt = (placement == `PLACE_SYM) ? `VAL_REGIONS_SYM
                                           : `VAL_REGIONS_PARAM;
    if (placement == `PLACE_SYM) begin
      region1 = (density == `DENS_512M) ? `DESC_MAIN_SYM_512
                                        : `DESC_MAIN_SYM_1G2G;
      region2 = `DESC_NONE;
    end else begin
      // 2Gb has no parameter build; treated as 1Gb main count
      region1 = (density == `DENS_512M) ? `DESC_MAIN_PARAM_512
                                        : `DESC_MAIN_PARAM_1G;
      region2 = `DESC_SMALL;
      if (placement == `PLACE_BOTTOM) begin
        region2 = region1;
        region1 = `DESC_SMALL;
      end
    end
  end

  // offset decode, unlisted offsets read zero
  always @* begin
    byte_out = 8'h00;
    if (offset == `OFS_CORE_MIN) begin
      byte_out = `VAL_CORE_MIN;
    end else if (offset == `OFS_CORE_MAX) begin
      byte_out = `VAL_CORE_MAX;
    end else if (offset == `OFS_PROG_MIN) begin
      byte_out = `VAL_PROG_MIN;
    end else if (offset == `OFS_PROG_MAX) begin
      byte_out = `VAL_PROG_MAX;
    end else if (offset == `OFS_TYP_WORD) begin
      byte_out = `VAL_TYP_WORD;
    end else if (offset == `OFS_TYP_BUF) begin
      byte_out = `VAL_TYP_BUF;
    end else if (offset == `OFS_TYP_BLK) begin
      byte_out = `VAL_TYP_BLK;
    end else if (offset == `OFS_TYP_CHIP) begin
      byte_out = `VAL_TYP_CHIP;
    end else if (offset == `OFS_MAX_WORD) begin
      byte_out = `VAL_MAX_WORD;
    end else if (offset == `OFS_MAX_BUF) begin
      byte_out = `VAL_MAX_BUF;
    end else if (offset == `OFS_MAX_BLK) begin
      byte_out = `VAL_MAX_BLK;
    end else if (offset == `OFS_MAX_CHIP) begin
      byte_out = `VAL_MAX_CHIP;
    end else if (offset == `OFS_SIZE) begin
      byte_out = size_exp;
    end else if (offset == `OFS_IFW_LO) begin
      byte_out = ifw_code[7:0];
    end else if (offset == `OFS_IFW_HI) begin
      byte_out = ifw_code[15:8];
    end else if (offset == `OFS_WBUF_LO) begin
      byte_out = wbuf_code[7:0];
    end else if (offset == `OFS_WBUF_HI) begin
      byte_out = wbuf_code[15:8];
    end else if (offset == `OFS_REGION_CNT) begin
      byte_out = region_cnt;
    end else if (rel1 < 8'h04) begin
      byte_out = region1[{rel1[1:0], 3'b000} +: 8];
    end else if (rel2 < 8'h04) begin
      byte_out = region2[{rel2[1:0], 3'b000} +: 8];
    end else if (offset >= `OFS_RSVD_FIRST &&
                 offset <= `OFS_RSVD_LAST) begin
      byte_out = 8'h00;
    end
  end

endmodule // cfi_table_rom

// ---- tb/qhost.sv ----
`timescale 1ns/1ps

// host side: issues query reads, one word per call
module qhost (
  input  logic       clk,
  output logic       query_mode,
  output logic       rd_en,
  output logic [7:0] word_addr
);
  initial begin
    query_mode = 1'b0;
    rd_en = 1'b0;
    word_addr = 8'h00;
  end
  // request held across the taking edge; caller releases with idle
  task rd(input logic [7:0] a, input logic q);
    query_mode = q;
    rd_en = 1'b1;
    word_addr = a;
    @(negedge clk);
  endtask
  // released address toggles so a stale value is never trusted
  task idle;
    rd_en = 1'b0;
    word_addr = ~word_addr;
  endtask
endmodule // qhost

// ---- tb/qtable_sva.sv ----
`timescale 1ns/1ps

// port-level checks of the query read path
module qtable_chk (
  input logic        clk,
  input logic        arst_n,
  input logic        query_mode,
  input logic        rd_en,
  input logic [7:0]  word_addr,
  input logic [15:0] rd_data,
  input logic        rd_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // a read taken while query mode is on
  sequence asked;
    rd_en && query_mode;
  endsequence
  sequence at(a);
    asked ##0 word_addr == a;
  endsequence
  // a taken read of a reserved word
  sequence asked_rsvd;
    asked ##0 word_addr inside {[8'h35:8'h38]};
  endsequence

  a_answer_lag: assert property (asked |-> ##2 rd_valid)
    else $error("read not answered after two cycles");
  a_no_spurious: assert property (
    rd_valid |-> $past(rd_en, 2) && $past(query_mode, 2))
    else $error("answer without a taken read");
  a_upper_zero: assert property (
    rd_valid |-> rd_data[15:8] == 8'h00)
    else $error("upper byte not zero");
  a_core_min: assert property (
    at(8'h1b) |-> ##2 rd_data == 16'h0017)
    else $error("core minimum wrong");
  a_prog_max: assert property (
    at(8'h1e) |-> ##2 rd_data == 16'h0095)
    else $error("programming maximum wrong");
  a_size_exp: assert property (
    at(8'h27) |-> ##2 rd_data == 16'h001a)
    else $error("size exponent wrong");
  a_rsvd_zero: assert property (
    asked_rsvd |-> ##2 rd_data == 16'h0000)
    else $error("reserved word not zero");
  a_data_hold: assert property (
    !rd_valid |-> $stable(rd_data))
    else $error("data moved without an answer");
endmodule // qtable_chk

// ---- tb/testbench.sv ----
`timescale 1ns/1ps

module testbench;
  logic        clk;
  logic        arst_n;
  logic        query_mode;
  logic        rd_en;
  logic [7:0]  word_addr;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic [15:0] rd_data_bot;
  logic [15:0] rd_data_sym;
  logic        rd_valid_bot;
  logic        rd_valid_sym;
  logic [2:0]  valids;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cyc = 0;
  // offset, then the byte of the 512Mb top, bottom and symmetric tables
  logic [31:0] rows [30] = '{32'h1b171717, 32'h1c202020, 32'h1d858585,
    32'h1e959595, 32'h1f090909, 32'h200a0a0a, 32'h210a0a0a, 32'h22000000,
    32'h23010101, 32'h24020202, 32'h25020202, 32'h26000000, 32'h271a1a1a,
    32'h28010101, 32'h29000000, 32'h2a0a0a0a, 32'h2b000000, 32'h2c020201,
    32'h2dfe03ff, 32'h2e010001, 32'h2f008000, 32'h30020002, 32'h3103fe00,
    32'h32000100, 32'h33800000, 32'h34000200, 32'h35000000, 32'h36000000,
    32'h37000000, 32'h38000000};

  assign valids = {rd_valid_sym, rd_valid_bot, rd_valid};

  qhost h (.clk(clk), .query_mode(query_mode), .rd_en(rd_en),
           .word_addr(word_addr));
  cfi_geometry_query_table dut (.clk(clk), .arst_n(arst_n),
    .query_mode(query_mode), .rd_en(rd_en), .word_addr(word_addr),
    .rd_data(rd_data), .rd_valid(rd_valid));
  // same reads against the bottom and symmetric 512Mb builds
  cfi_geometry_query_table #(.density(2'h0), .placement(2'h1)) dut_bot (
    .clk(clk), .arst_n(arst_n), .query_mode(query_mode), .rd_en(rd_en),
    .word_addr(word_addr), .rd_data(rd_data_bot), .rd_valid(rd_valid_bot));
  cfi_geometry_query_table #(.density(2'h0), .placement(2'h2)) dut_sym (
    .clk(clk), .arst_n(arst_n), .query_mode(query_mode), .rd_en(rd_en),
    .word_addr(word_addr), .rd_data(rd_data_sym), .rd_valid(rd_valid_sym));

  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one read; returns while the answer pulse stands
  task one(input logic [7:0] a, input logic q);
    h.rd(a, q);
    h.idle;
    @(negedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, far above the roughly one hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      miscompares++;
      close_out;
    end
  end

  initial begin
    arst_n = 1'b0;
    @(negedge clk);
    chk("reset data", rd_data, 16'h0000);
    chk("reset valid", {15'h0, rd_valid}, 16'h0001 ^ 16'h0001);
    @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 30; i++) begin
      one(rows[i][31:24], 1'b1);
      chk("top", rd_data, {8'h00, rows[i][23:16]}); // to
      chk("bottom", rd_data_bot, {8'h00, rows[i][15:8]});
      chk("symmetric", rd_data_sym, {8'h00, rows[i][7:0]});
      chk("valid", {13'h0, valids}, 16'h0007);
      @(negedge clk);
      chk("pulse", {13'h0, valids}, 16'h0000);
    end
    // back to back reads, answers on consecutive cycles
    h.rd(8'h1b, 1'b1);
    h.rd(8'h1c, 1'b1);
    h.idle;
    chk("first", rd_data, 16'h0017);
    @(negedge clk);
    chk("second", rd_data, 16'h0020);
    chk("second valid", {15'h0, rd_valid}, 16'h0001);
    // outside query mode: ignored, data kept; unlisted word 10h reads zero
    one(8'h1d, 1'b0);
    chk("refused data", rd_data, 16'h0020);
    chk("refused valid", {15'h0, rd_valid}, 16'h0000);
    one(8'h10, 1'b1);
    chk("outside", rd_data, 16'h0000);
    // reset in mid-run clears the answer, reads resume at once
    one(8'h2c, 1'b1);
    chk("count", rd_data, 16'h0002);
    arst_n = 1'b0;
    @(negedge clk);
    chk("mid reset data", rd_data, 16'h0000);
    chk("mid reset valid", {15'h0, rd_valid}, 16'h0000);
    arst_n = 1'b1;
    one(8'h2d, 1'b1);
    chk("after reset", rd_data, 16'h00fe);
    close_out;
  end
endmodule // testbench

bind cfi_geometry_query_table qtable_chk u_chk (.clk(clk), .arst_n(arst_n),
  .query_mode(query_mode), .rd_en(rd_en), .word_addr(word_addr),
  .rd_data(rd_data), .rd_valid(rd_valid));
